//--- common/lset_edge_if.sv
/*
 * Edge events and counts passed from the edge counter to the sync timer.
 * Assumes all parties run on clk_sys.
 */
`timescale 1ns/1ns
interface lset_edge_if;
    import lset_pkg::*;
    logic             hold_clr;
    logic             fall_evt;
    logic             rise_evt;
    logic [CNT_W-1:0] fall_cnt;
    logic [CNT_W-1:0] rise_cnt;

    modport counter (input hold_clr, output fall_evt, rise_evt, fall_cnt, rise_cnt);
    modport timer   (input hold_clr, fall_evt, rise_evt, fall_cnt, rise_cnt);
    modport ctrl    (output hold_clr, input fall_cnt, rise_cnt);
endinterface

//--- common/lset_pkg.sv
/*
 * Constants, register map and types shared by the LIN sync edge timer.
 * Assumes a 100 MHz system clock and a 32-bit byte-addressed register port.
 */
package lset_pkg;
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TICK_HZ       = 5_000_000;
    localparam int unsigned TICK_DIV      = CLK_HZ / TICK_HZ;
    localparam int unsigned TICK_W        = $clog2(TICK_DIV);
    localparam int unsigned RST_DELAY_NS  = 15_000;
    localparam int unsigned RST_DELAY_CYC = (RST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RST_CNT_W     = $clog2(RST_DELAY_CYC + 1);

    localparam int unsigned ADDR_W  = 32;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned CNT_W   = 4;
    localparam int unsigned VALUE_W = 16;
    localparam int unsigned CTRL_W  = 16;
    localparam int unsigned EDGE_W  = 8;

    localparam logic [ADDR_W-1:0] OFF_STATUS = 32'hFFFF_0780;
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 32'hFFFF_0784;
    localparam logic [ADDR_W-1:0] OFF_VALUE  = 32'hFFFF_0788;
    localparam logic [ADDR_W-1:0] OFF_EDGE   = 32'hFFFF_078C;

    localparam int unsigned CTRL_RESET_BIT    = 0;
    localparam int unsigned CTRL_CLEAR_BIT    = 1;
    localparam int unsigned CTRL_ENABLE_BIT   = 2;
    localparam int unsigned CTRL_START_IE_BIT = 3;
    localparam int unsigned CTRL_STOP_IE_BIT  = 4;
    localparam int unsigned CTRL_STOP_RISE_BIT = 7;
    localparam int unsigned CTRL_GATE_RX_BIT  = 8;
    localparam logic [CTRL_W-1:0] CTRL_WMASK     = 16'h019F;
    localparam logic [CTRL_W-1:0] CTRL_RESET_VAL = 16'h0000;

    localparam int unsigned EDGE_START_LSB = 0;
    localparam int unsigned EDGE_STOP_LSB  = 4;
    localparam logic [EDGE_W-1:0] EDGE_RESET_VAL = 8'h32;

    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_RUN_BIT  = 1;
    localparam int unsigned STAT_DONE_BIT = 2;
    localparam int unsigned STAT_FALL_LSB = 8;
    localparam int unsigned STAT_RISE_LSB = 12;

    typedef enum logic [1:0] {LSET_IDLE, LSET_RUN, LSET_DONE} lset_state_t;

    function automatic logic [CNT_W-1:0] lset_sat_inc(input logic [CNT_W-1:0] v);
        lset_sat_inc = (v == 4'hF) ? v : v + 4'h1;
    endfunction
endpackage

//--- hw/lset_edge_counter.sv
/*
 * Counts falling and rising edges of the LIN receive line.
 * Assumes lin_rx is synchronous to clk_sys; idle bus level is high.
 */
`timescale 1ns/1ns
module lset_edge_counter
    import lset_pkg::*;
(
    input  wire logic   clk_sys,
    input  wire logic   rst_b,
    input  wire logic   lin_rx,
    lset_edge_if.counter edge_bus
);
    logic             rx_prev_reg;
    logic             fall_evt_reg;
    logic             rise_evt_reg;
    logic [CNT_W-1:0] fall_cnt_reg;
    logic [CNT_W-1:0] rise_cnt_reg;
    wire              fall_seen = rx_prev_reg & ~lin_rx;
    wire              rise_seen = ~rx_prev_reg & lin_rx;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_prev_reg  <= 1'b1;
            fall_evt_reg <= 1'b0;
            rise_evt_reg <= 1'b0;
            fall_cnt_reg <= '0;
            rise_cnt_reg <= '0;
        end
        else
        begin
            rx_prev_reg  <= lin_rx;
            fall_evt_reg <= fall_seen & ~edge_bus.hold_clr;
            rise_evt_reg <= rise_seen & ~edge_bus.hold_clr;
            fall_cnt_reg <= edge_bus.hold_clr ? '0 :
                            (fall_seen ? lset_sat_inc(fall_cnt_reg) : fall_cnt_reg);
            rise_cnt_reg <= edge_bus.hold_clr ? '0 :
                            (rise_seen ? lset_sat_inc(rise_cnt_reg) : rise_cnt_reg);
        end
    end

    assign edge_bus.fall_evt = fall_evt_reg;
    assign edge_bus.rise_evt = rise_evt_reg;
    assign edge_bus.fall_cnt = fall_cnt_reg;
    assign edge_bus.rise_cnt = rise_cnt_reg;
endmodule // lset_edge_counter

//--- hw/lset_sync_timer.sv
/*
 * Sync timer: runs on 5 MHz ticks from the start edge to the stop edge.
 * Assumes registered edge events whose counts are already updated.
 */
`timescale 1ns/1ns
module lset_sync_timer
    import lset_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire logic               rst_b,
    input  wire logic               tick,
    input  wire logic [CNT_W-1:0]   start_cnt,
    input  wire logic [CNT_W-1:0]   stop_cnt,
    input  wire logic               stop_rise,
    lset_edge_if.timer              edge_bus,
    output logic      [VALUE_W-1:0] value,
    output logic                    running,
    output logic                    done,
    output logic                    start_evt,
    output logic                    stop_evt
);
    lset_state_t        state_reg;
    logic [VALUE_W-1:0] value_reg;
    logic               start_evt_reg;
    logic               stop_evt_reg;

    wire start_hit = edge_bus.fall_evt && (edge_bus.fall_cnt == start_cnt);
    wire stop_fall = edge_bus.fall_evt && (edge_bus.fall_cnt == stop_cnt);
    wire stop_rhit = edge_bus.rise_evt && (edge_bus.rise_cnt == stop_cnt);
    wire stop_hit  = stop_rise ? stop_rhit : stop_fall;
    wire [VALUE_W-1:0] value_inc = (value_reg == 16'hFFFF) ? value_reg : value_reg + 16'h0001;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg     <= LSET_IDLE;
            value_reg     <= '0;
            start_evt_reg <= 1'b0;
            stop_evt_reg  <= 1'b0;
        end
        else
        begin
            start_evt_reg <= 1'b0;
            stop_evt_reg  <= 1'b0;
            if (edge_bus.hold_clr)
            begin
                state_reg <= LSET_IDLE;
                value_reg <= '0;
            end
            else
            begin
                unique case (state_reg)
                    LSET_IDLE:
                    begin
                        if (start_hit)
                        begin
                            state_reg     <= LSET_RUN;
                            value_reg     <= '0;
                            start_evt_reg <= 1'b1;
                        end
                    end
                    LSET_RUN:
                    begin
                        if (stop_hit)
                        begin
                            state_reg    <= LSET_DONE;
                            stop_evt_reg <= 1'b1;
                        end
                        else if (tick)
                        begin
                            value_reg <= value_inc;
                        end
                    end
                    LSET_DONE:
                    begin
                        state_reg <= LSET_DONE;
                    end
                endcase
            end
        end
    end

    assign value     = value_reg;
    assign running   = (state_reg == LSET_RUN);
    assign done      = (state_reg == LSET_DONE);
    assign start_evt = start_evt_reg;
    assign stop_evt  = stop_evt_reg;
endmodule // lset_sync_timer

//--- hw/lset_top.sv
/*
 * LIN hardware synchronizer: edge counting, sync timing, register port.
 * Assumes lin_rx synchronous to clk_sys, and a master that reads the
 * read data in the cycle after the read strobe.
 */
//
// Contract
// - Unit works only while enable bit set; uart_rx_gate still follows the gate bit while disabled
// - Clear bit holds edge counters cleared
// - Reset bit returns logic to defaults; the other control bits written with it stay set
// - Reset bit self-clears after 15 us
// - Stop count field, default third edge
// - Start count field, default second falling edge
// - Value register reads timer, ignores writes
// - Timer increments on 5 MHz tick
// - Stop edge type selects falling or rising
// - Stop interrupt only when enabled
`timescale 1ns/1ns
module lset_top
    import lset_pkg::*;
(
    input  wire logic                       clk_sys,
    input  wire logic                       rst_b,
    input  wire logic                       lin_rx,
    input  wire logic [lset_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [lset_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [lset_pkg::DATA_W-1:0] reg_rdata,
    output logic                            irq_start,
    output logic                            irq_stop,
    output logic                            uart_rx_gate
);
    import lset_pkg::*;

    localparam logic [RST_CNT_W-1:0] RST_CNT_LAST  = RST_CNT_W'(RST_DELAY_CYC - 1);
    localparam logic [TICK_W-1:0]    TICK_CNT_LAST = TICK_W'(TICK_DIV - 1);

    // Register state
    logic [CTRL_W-1:0]    ctrl_reg;
    logic [CTRL_W-1:0]    ctrl_next;
    logic [EDGE_W-1:0]    edge_reg;
    logic [EDGE_W-1:0]    edge_next;
    logic [RST_CNT_W-1:0] rst_cnt_reg;
    logic [RST_CNT_W-1:0] rst_cnt_next;
    logic [TICK_W-1:0]    tick_cnt_reg;
    logic [TICK_W-1:0]    tick_cnt_next;
    logic                 tick_reg;
    logic                 tick_next;
    logic [DATA_W-1:0]    rdata_reg;
    logic [DATA_W-1:0]    rdata_next;
    logic                 irq_start_reg;
    logic                 irq_start_next;
    logic                 irq_stop_reg;
    logic                 irq_stop_next;
    logic                 gate_reg;
    logic                 gate_next;

    // Timer results
    logic [VALUE_W-1:0]   timer_value;
    logic                 timer_running;
    logic                 timer_done;
    logic                 timer_start_evt;
    logic                 timer_stop_evt;

    // Edge events and counts shared by counter and timer
    lset_edge_if edge_bus ();

    // Exact match on all address bits
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        addr_hit = (a == off);
    endfunction

    // Address decode
    wire hit_status = addr_hit(reg_addr, OFF_STATUS);
    wire hit_ctrl   = addr_hit(reg_addr, OFF_CTRL);
    wire hit_value  = addr_hit(reg_addr, OFF_VALUE);
    wire hit_edge   = addr_hit(reg_addr, OFF_EDGE);
    wire wr_ctrl    = reg_wr & hit_ctrl;
    wire wr_edge    = reg_wr & hit_edge;

    // Control fields
    wire rst_busy    = ctrl_reg[CTRL_RESET_BIT];
    wire cnt_clear   = ctrl_reg[CTRL_CLEAR_BIT];
    wire unit_enable = ctrl_reg[CTRL_ENABLE_BIT];
    wire start_ie    = ctrl_reg[CTRL_START_IE_BIT];
    wire stop_ie     = ctrl_reg[CTRL_STOP_IE_BIT];
    wire stop_rise   = ctrl_reg[CTRL_STOP_RISE_BIT];
    wire gate_rx_en  = ctrl_reg[CTRL_GATE_RX_BIT];

    wire [CNT_W-1:0] start_cnt = edge_reg[EDGE_START_LSB +: CNT_W];
    wire [CNT_W-1:0] stop_cnt  = edge_reg[EDGE_STOP_LSB +: CNT_W];

    wire [CTRL_W-1:0] ctrl_wval = reg_wdata[CTRL_W-1:0] & CTRL_WMASK;
    wire [EDGE_W-1:0] edge_wval = reg_wdata[EDGE_W-1:0];
    wire              rst_set   = wr_ctrl & ctrl_wval[CTRL_RESET_BIT];

    // Soft reset count-up ends on the last cycle of the delay
    wire rst_expire = rst_busy & (rst_cnt_reg == RST_CNT_LAST);

    // Counters and timer are held cleared while disabled, clearing or resetting
    assign edge_bus.hold_clr = rst_busy | cnt_clear | ~unit_enable;

    // Control value with the soft reset bit dropped
    wire [CTRL_W-1:0] ctrl_selfclr = ctrl_reg & ~CTRL_W'(1 << CTRL_RESET_BIT);

    // Control register: a software write wins over the self-clear
    assign ctrl_next = wr_ctrl    ? ctrl_wval :
                       rst_expire ? ctrl_selfclr :
                                    ctrl_reg;

    // Edge configuration returns to default during a soft reset
    assign edge_next = (rst_set | rst_busy) ? EDGE_RESET_VAL :
                       wr_edge             ? edge_wval :
                                             edge_reg;

    assign rst_cnt_next = rst_set    ? '0 :
                          rst_expire ? '0 :
                          rst_busy   ? rst_cnt_reg + RST_CNT_W'(1) :
                                       '0;

    // 5 MHz timer tick from the system clock
    // Free-running phase: a span may read one tick short
    wire tick_wrap = (tick_cnt_reg == TICK_CNT_LAST);
    assign tick_cnt_next = tick_wrap ? '0 : tick_cnt_reg + TICK_W'(1);
    assign tick_next     = tick_wrap;

    // Interrupt pulses
    assign irq_start_next = timer_start_evt & start_ie;
    assign irq_stop_next  = timer_stop_evt & stop_ie;

    // UART receive gated until the sync field has been timed
    assign gate_next = gate_rx_en & ~timer_done;

    // Read data
    wire [DATA_W-1:0] rd_status = {
        16'h0000,
        edge_bus.rise_cnt,
        edge_bus.fall_cnt,
        5'h00,
        timer_done,
        timer_running,
        rst_busy
    };
    wire [DATA_W-1:0] rd_ctrl  = {16'h0000, ctrl_reg};
    wire [DATA_W-1:0] rd_value = {16'h0000, timer_value};
    wire [DATA_W-1:0] rd_edge  = {24'h000000, edge_reg};
    wire [DATA_W-1:0] rd_sel   = hit_status ? rd_status :
                                 hit_ctrl   ? rd_ctrl :
                                 hit_value  ? rd_value :
                                 hit_edge   ? rd_edge :
                                              32'h0000_0000;
    assign rdata_next = reg_rd ? rd_sel : 32'h0000_0000;

    // Control register
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_reg <= CTRL_RESET_VAL;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Edge configuration register
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            edge_reg <= EDGE_RESET_VAL;
        end
        else
        begin
            edge_reg <= edge_next;
        end
    end

    // Soft reset delay counter
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_cnt_reg <= '0;
        end
        else
        begin
            rst_cnt_reg <= rst_cnt_next;
        end
    end

    // Tick divider
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tick_cnt_reg <= '0;
        end
        else
        begin
            tick_cnt_reg <= tick_cnt_next;
        end
    end

    // Tick strobe
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tick_reg <= 1'b0;
        end
        else
        begin
            tick_reg <= tick_next;
        end
    end

    // Read data, zero outside the answer cycle
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata_reg <= '0;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    // Start pulse
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_start_reg <= 1'b0;
        end
        else
        begin
            irq_start_reg <= irq_start_next;
        end
    end

    // Stop pulse
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_stop_reg <= 1'b0;
        end
        else
        begin
            irq_stop_reg <= irq_stop_next;
        end
    end

    // UART receive gate
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            gate_reg <= 1'b0;
        end
        else
        begin
            gate_reg <= gate_next;
        end
    end

    // Edge counter on the receive line
    lset_edge_counter u_edge_counter (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .lin_rx   (lin_rx),
        .edge_bus (edge_bus.counter)
    );

    // Sync timer from start edge to stop edge
    lset_sync_timer u_sync_timer (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .tick      (tick_reg),
        .start_cnt (start_cnt),
        .stop_cnt  (stop_cnt),
        .stop_rise (stop_rise),
        .edge_bus  (edge_bus.timer),
        .value     (timer_value),
        .running   (timer_running),
        .done      (timer_done),
        .start_evt (timer_start_evt),
        .stop_evt  (timer_stop_evt)
    );

    assign reg_rdata    = rdata_reg;
    assign irq_start    = irq_start_reg;
    assign irq_stop     = irq_stop_reg;
    assign uart_rx_gate = gate_reg;
endmodule // lset_top

//--- tb/lset_assertions.sv
/*
 * Port checker for lset_top, bound to every instance.
 * Assumes one clock domain and the reset defaults of the package.
 */
`timescale 1ns/1ns
module lset_assertions
    import lset_pkg::*;
(
    input wire logic                        clk_sys,
    input wire logic                        rst_b,
    input wire logic                        lin_rx,
    input wire logic [lset_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [lset_pkg::DATA_W-1:0] reg_wdata,
    input wire logic                        reg_wr,
    input wire logic                        reg_rd,
    input wire logic [lset_pkg::DATA_W-1:0] reg_rdata,
    input wire logic                        irq_start,
    input wire logic                        irq_stop,
    input wire logic                        uart_rx_gate
);
    logic [5:0] rx_hist;
    wire logic  mapped;
    wire logic  edge_recent;
    assign mapped = reg_addr inside {OFF_STATUS, OFF_CTRL, OFF_VALUE, OFF_EDGE};
    // Any line change across the last six samples
    assign edge_recent = |(rx_hist[5:1] ^ rx_hist[4:0]);
    always_ff @(posedge clk_sys or negedge rst_b)
        if (!rst_b)
            rx_hist <= '1;
        else
            rx_hist <= {rx_hist[4:0], lin_rx};

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    property p_rd_idle; !reg_rd |=> reg_rdata == '0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
    property p_rd_high; reg_rd |=> reg_rdata[31:16] == '0; endproperty
    a_rd_high: assert property (p_rd_high) else $error("upper read bits set");
    property p_unmapped; reg_rd && !mapped |=> reg_rdata == '0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_edge_w; reg_rd && reg_addr == OFF_EDGE |=> reg_rdata[31:8] == '0; endproperty
    a_edge_w: assert property (p_edge_w) else $error("edge config wider than 8 bits");
    property p_ctrl_mask;
        reg_rd && reg_addr == OFF_CTRL |=> (reg_rdata[15:0] & ~CTRL_WMASK) == '0;
    endproperty
    a_ctrl_mask: assert property (p_ctrl_mask) else $error("reserved ctrl bits set");
    property p_start_pulse; irq_start |=> !irq_start; endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
    property p_stop_pulse; irq_stop |=> !irq_stop; endproperty
    a_stop_pulse: assert property (p_stop_pulse) else $error("stop pulse too long");
    property p_not_both; !(irq_start && irq_stop); endproperty
    a_not_both: assert property (p_not_both) else $error("start and stop together");
    property p_stop_cause; irq_stop |-> edge_recent; endproperty
    a_stop_cause: assert property (p_stop_cause) else $error("stop without line edge");
    property p_start_cause; irq_start |-> edge_recent; endproperty
    a_start_cause: assert property (p_start_cause) else $error("start without line edge");
    property p_gate_done; irq_stop |=> !uart_rx_gate; endproperty
    a_gate_done: assert property (p_gate_done) else $error("gate still set after stop");

    c_stop: cover property (irq_stop);
    c_start: cover property (irq_start);
    c_gate: cover property (uart_rx_gate ##1 !uart_rx_gate);
endmodule // lset_assertions

bind lset_top lset_assertions lset_assertions_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .lin_rx(lin_rx), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq_start(irq_start), .irq_stop(irq_stop), .uart_rx_gate(uart_rx_gate)
);

//--- tb/lset_lin_master.sv
/*
 * LIN master model: sends break and sync byte on lin_rx.
 * Assumes the bus idles high through its pull-up between frames.
 */
`timescale 1ns/1ns
module lset_lin_master
(
    input  wire logic clk_sys,
    output logic      lin_rx
);
    initial lin_rx = 1'b1;
    task automatic send_bit(input logic b, input int bit_cyc);
        lin_rx <= b;
        repeat (bit_cyc) @(posedge clk_sys);
    endtask
    // Break of 13 bits, delimiter, then 0x55 with start and stop bits
    task automatic send_header(input int bit_cyc);
        logic [9:0] sync;
        sync = {1'b1, 8'h55, 1'b0};
        @(posedge clk_sys);
        for (int i = 0; i < 13; i++) send_bit(1'b0, bit_cyc);
        send_bit(1'b1, bit_cyc);
        for (int i = 0; i < 10; i++) send_bit(sync[i], bit_cyc);
    endtask
endmodule // lset_lin_master

//--- tb/testbench.sv
/*
 * Self-checking bench for lset_top driven by a LIN master model.
 * Assumes 100 MHz clk_sys and a 20-cycle timer tick.
 */
`timescale 1ns/1ns
module testbench;
    import lset_pkg::*;
    localparam int BIT_CYC = 200;
    logic              clk_sys;
    logic              rst_b;
    logic              lin_rx;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic              irq_start;
    logic              irq_stop;
    logic              uart_rx_gate;
    logic [DATA_W-1:0] rd;
    logic [DATA_W-1:0] held;
    int                err_count;
    int                num_checks;
    int                starts;
    int                stops;

    lset_top lset_top_i (.clk_sys(clk_sys), .rst_b(rst_b), .lin_rx(lin_rx),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq_start(irq_start), .irq_stop(irq_stop),
        .uart_rx_gate(uart_rx_gate));
    lset_lin_master lset_lin_master_i (.clk_sys(clk_sys), .lin_rx(lin_rx));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        if (irq_start === 1'b1) starts++;
        if (irq_stop === 1'b1) stops++;
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            err_count++;
        end
    endtask
    task automatic check_rng(input logic [31:0] got, input logic [31:0] lo, hi);
        num_checks++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            $display("unexpected at %0t: got %h exp %h to %h", $time, got, lo, hi);
            err_count++;
        end
    endtask
    task automatic reg_write(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask
    task automatic reg_read(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
    // Disable clears the counters, then configure and send one header
    task automatic frame(input logic [31:0] edges, input logic [31:0] ctrl);
        reg_write(OFF_CTRL, 32'h0);
        reg_write(OFF_EDGE, edges);
        reg_write(OFF_CTRL, ctrl);
        starts = 0;
        stops = 0;
        lset_lin_master_i.send_header(BIT_CYC);
        repeat (10) @(posedge clk_sys);
        reg_read(OFF_VALUE, rd);
    endtask

    task automatic t_defaults();
        reg_read(OFF_CTRL, rd);
        check(rd, 32'h0);
        reg_read(OFF_EDGE, rd);
        check(rd, 32'h32);
        reg_read(OFF_VALUE, rd);
        check(rd, 32'h0);
        reg_read(32'hFFFF_0790, rd);
        check(rd, 32'h0);
    endtask
    task automatic t_default_sync();
        frame(32'h32, 32'h001C);
        check_rng(rd, 19, 21);
        check(32'(starts), 32'h1);
        check(32'(stops), 32'h1);
        held = rd;
        reg_write(OFF_VALUE, 32'hFFFF);
        repeat (100) @(posedge clk_sys);
        reg_read(OFF_VALUE, rd);
        check(rd, held);
    endtask
    task automatic t_soft();
        reg_write(OFF_EDGE, 32'h55);
        reg_write(OFF_CTRL, 32'h0015);
        reg_write(OFF_EDGE, 32'h77);
        reg_read(OFF_EDGE, rd);
        check(rd, 32'h32);
        reg_read(OFF_VALUE, rd);
        check(rd, 32'h0);
        repeat (1400) @(posedge clk_sys);
        reg_read(OFF_CTRL, rd);
        check(rd, 32'h15);
        repeat (200) @(posedge clk_sys);
        reg_read(OFF_CTRL, rd);
        check(rd, 32'h14);
    endtask
    task automatic t_fifth();
        reg_write(OFF_CTRL, 32'h0114);
        repeat (2) @(negedge clk_sys);
        check(32'(uart_rx_gate), 32'h1);
        frame(32'h62, 32'h0114);
        check_rng(rd, 79, 81);
        check_rng(rd * TICK_DIV / 8, BIT_CYC - 5, BIT_CYC + 5);
        check(32'(stops), 32'h1);
        check(32'(uart_rx_gate), 32'h0);
    endtask
    task automatic t_rising();
        frame(32'h32, 32'h0084);
        check_rng(rd, 29, 31);
        check(32'(stops), 32'h0);
    endtask
    task automatic t_clear();
        frame(32'h32, 32'h0006);
        check(rd, 32'h0);
        reg_read(OFF_STATUS, rd);
        check(32'(rd[11:8]), 32'h0);
        frame(32'h32, 32'h0004);
        check_rng(rd, 19, 21);
    endtask
    task automatic t_disable();
        frame(32'h32, 32'h0010);
        check(rd, 32'h0);
        check(32'(stops), 32'h0);
    endtask

    initial
    begin
        rst_b = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        err_count = 0;
        num_checks = 0;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_defaults();
        t_default_sync();
        t_soft();
        t_fifth();
        t_rising();
        t_clear();
        t_disable();
        complete_run();
    end
    initial
    begin
        #500_000;
        err_count++;
        complete_run();
    end
endmodule // testbench
